// file: src/wake_source_enable_gating.sv
// Notes on behaviour
// - A source drives the wake request only when its enable, its status and the global enable are all 1.
// - A source whose enable is 0 still records events in its status bit but never drives the request.
// - Both enable registers clear to zero only on the standby-rail reset and survive every other reset.
// - The register at 0x0b is read/write and its bits 0 to 7 enable port 1 pins 0 to 7 as sources.
// - The register at 0x0c is read/write; bits 0-2 enable port 2 pins 0-2 and bits 4-7 pins 4-7.
// - Bit 3 of the register at 0x0c enables the grouped SMI output instead of a pin source.
// - Writing 1 to a wake status bit clears it and writing 0 leaves it unchanged.
// - A status bit is set whenever its source is active, whatever its enable or the global enable.
module wake_source_enable_gating
  import wake_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic              clk_en_in,
  input  wire reg_req_type       reg_req_in,
  input  wire logic [PIN_W-1:0]  wake_pin_in,
  output logic      [DATA_W-1:0] rd_data_out,
  output logic                   wake_request_n_out,
  output logic                   group_smi_out,
  output logic                   irq_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PIN_W-1:0]  pin_meta_q;
  logic [PIN_W-1:0]  pin_sync_q;
  logic [SRC_W-1:0]  src_active;
  logic [SRC_W-1:0]  status_q;
  logic [SRC_W-1:0]  status_d;
  logic [SRC_W-1:0]  sts_clear;
  logic [SRC_W-1:0]  enable_all;
  logic [SRC_W-1:0]  gated;
  logic [DATA_W-1:0] wake_enable_pins_1x_q;
  logic [DATA_W-1:0] wake_enable_pins_2x_q;
  logic              wake_global_enable_q;
  logic              group_smi_enable;
  logic [INT_W-1:0]  int_sts_q;
  logic [INT_W-1:0]  int_mask_q;
  logic [INT_W-1:0]  int_event;
  logic              wake_any;
  logic              smi_any;
  logic              req_prev_q;
  logic              wr_en_1x;
  logic              wr_en_2x;
  logic              wr_sts_1x;
  logic              wr_sts_2x;
  logic              wr_ctrl;
  logic              wr_int_sts;
  logic              wr_int_mask;
  logic [DATA_W-1:0] rd_data_d;
  logic              wake_request_n_q;
  logic              group_smi_q;
  logic              irq_q;
  logic [DATA_W-1:0] rd_data_q;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Pins are asynchronous; only the second stage is read by logic
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else if (clk_en_in)
    begin
      pin_meta_q <= wake_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Port 2 pin 3 has no source, its slot carries the SMI enable
  assign src_active = {pin_sync_q[PIN_W-1:NO_SRC_BIT], 1'b0, pin_sync_q[NO_SRC_BIT-1:0]};

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign wr_en_1x    = reg_req_in.wr && (reg_req_in.addr == OFF_EN_1X);
  assign wr_en_2x    = reg_req_in.wr && (reg_req_in.addr == OFF_EN_2X);
  assign wr_sts_1x   = reg_req_in.wr && (reg_req_in.addr == OFF_STS_1X);
  assign wr_sts_2x   = reg_req_in.wr && (reg_req_in.addr == OFF_STS_2X);
  assign wr_ctrl     = reg_req_in.wr && (reg_req_in.addr == OFF_CTRL);
  assign wr_int_sts  = reg_req_in.wr && (reg_req_in.addr == OFF_INT_STS);
  assign wr_int_mask = reg_req_in.wr && (reg_req_in.addr == OFF_INT_MASK);

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------
  // rst_n_in is the standby-rail reset; the other resets never reach here
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      wake_enable_pins_1x_q <= RST_BYTE;
      wake_enable_pins_2x_q <= RST_BYTE;
    end
    else if (clk_en_in)
    begin
      if (wr_en_1x)
      begin
        wake_enable_pins_1x_q <= reg_req_in.wdata;
      end
      if (wr_en_2x)
      begin
        wake_enable_pins_2x_q <= reg_req_in.wdata;
      end
    end
  end

  // Bit 3 of the second enable is not a pin enable
  assign group_smi_enable = wake_enable_pins_2x_q[SMI_EN_BIT];
  assign enable_all = {wake_enable_pins_2x_q, wake_enable_pins_1x_q} & SRC_PRESENT;

  // ----------------------------------------------------------------
  // Global enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      wake_global_enable_q <= 1'b0;
    end
    else if (clk_en_in && wr_ctrl)
    begin
      wake_global_enable_q <= reg_req_in.wdata[CTRL_GLOBAL];
    end
  end

  // ----------------------------------------------------------------
  // Wake status
  // ----------------------------------------------------------------
  assign sts_clear = {(wr_sts_2x ? reg_req_in.wdata : READ_ZERO),
                      (wr_sts_1x ? reg_req_in.wdata : READ_ZERO)};

  // Set beats a same-cycle clear so no event is lost
  for (genvar i = 0; i < SRC_W; i++)
  begin : g_status
    assign status_d[i] = SRC_PRESENT[i] &&
                         (src_active[i] || (status_q[i] && !sts_clear[i]));
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      status_q <= RST_SRC;
    end
    else if (clk_en_in)
    begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------------------------------
  // Gating and request
  // ----------------------------------------------------------------
  // Global enable gates the request only, never the status
  assign gated    = status_q & enable_all & {SRC_W{wake_global_enable_q}};
  assign wake_any = |gated;
  assign smi_any  = group_smi_enable && |(status_q & enable_all);

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      wake_request_n_q <= 1'b1;
      group_smi_q      <= 1'b0;
      req_prev_q       <= 1'b0;
    end
    else if (clk_en_in)
    begin
      wake_request_n_q <= !wake_any;
      group_smi_q      <= smi_any;
      req_prev_q       <= wake_any;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  assign int_event[INT_STS_SET]  = |(src_active & ~status_q);
  assign int_event[INT_REQ_RISE] = wake_any && !req_prev_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      int_sts_q <= RST_INT;
    end
    else if (clk_en_in)
    begin
      int_sts_q <= int_event |
                   (int_sts_q & ~(wr_int_sts ? reg_req_in.wdata[INT_W-1:0] : RST_INT));
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      int_mask_q <= RST_INT;
    end
    else if (clk_en_in && wr_int_mask)
    begin
      int_mask_q <= reg_req_in.wdata[INT_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      irq_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      irq_q <= |(int_sts_d_next(int_sts_q, int_event, wr_int_sts, reg_req_in.wdata)
                 & int_mask_q);
    end
  end

  // Irq follows the status value being loaded, so it tracks it in step
  function automatic logic [INT_W-1:0] int_sts_d_next(input logic [INT_W-1:0]  sts,
                                                      input logic [INT_W-1:0]  ev,
                                                      input logic              wr,
                                                      input logic [DATA_W-1:0] data);
    int_sts_d_next = ev | (sts & ~(wr ? data[INT_W-1:0] : RST_INT));
  endfunction

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_data_d = READ_ZERO;
    unique case (reg_req_in.addr)
      OFF_EN_1X:    rd_data_d = wake_enable_pins_1x_q;
      OFF_EN_2X:    rd_data_d = wake_enable_pins_2x_q;
      OFF_STS_1X:   rd_data_d = status_q[DATA_W-1:0];
      OFF_STS_2X:   rd_data_d = status_q[SRC_W-1:DATA_W];
      OFF_CTRL:     rd_data_d = {{(DATA_W-1){1'b0}}, wake_global_enable_q};
      OFF_INT_STS:  rd_data_d = {{(DATA_W-INT_W){1'b0}}, int_sts_q};
      OFF_INT_MASK: rd_data_d = {{(DATA_W-INT_W){1'b0}}, int_mask_q};
      default:      rd_data_d = READ_ZERO;
    endcase
  end

  // Read data stand one cycle after the strobe and only there
  // Zero outside the answer cycle, so a stray sample reads harmless
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      rd_data_q <= READ_ZERO;
    end
    else if (clk_en_in)
    begin
      rd_data_q <= reg_req_in.rd ? rd_data_d : READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Registered outputs keep decode glitches off the far side
  assign rd_data_out        = rd_data_q;
  assign wake_request_n_out = wake_request_n_q;
  assign group_smi_out      = group_smi_q;
  assign irq_out            = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  a_request_gating: assert property (
    clk_en_in |=> wake_request_n_out == !$past(|(status_q & enable_all)
                                               & wake_global_enable_q))
    else $error("wake request does not follow gated status");

  a_disabled_records: assert property (
    (clk_en_in && |(src_active & ~enable_all & SRC_PRESENT))
    |=> ((status_q & $past(src_active & ~enable_all & SRC_PRESENT))
         == $past(src_active & ~enable_all & SRC_PRESENT)))
    else $error("disabled source event not recorded");

  a_enable_hold: assert property (
    (!(clk_en_in && (wr_en_1x || wr_en_2x)))
    |=> $stable(wake_enable_pins_1x_q) && $stable(wake_enable_pins_2x_q))
    else $error("enable register changed without a write");

  a_enable_1x_write: assert property (
    (clk_en_in && wr_en_1x) |=> wake_enable_pins_1x_q == $past(reg_req_in.wdata))
    else $error("first enable register write lost");

  a_enable_2x_write: assert property (
    (clk_en_in && wr_en_2x) ##1 (clk_en_in && reg_req_in.rd && reg_req_in.addr == OFF_EN_2X)
    |=> rd_data_out == $past(reg_req_in.wdata, 2))
    else $error("second enable register readback wrong");

  a_group_smi: assert property (
    clk_en_in |=> group_smi_out == $past(wake_enable_pins_2x_q[SMI_EN_BIT]
                                         && |(status_q & enable_all)))
    else $error("group smi output wrong");

  a_status_clear: assert property (
    (clk_en_in && wr_sts_1x && !(|pin_sync_q[DATA_W-1:0]))
    |=> status_q[DATA_W-1:0] == $past(status_q[DATA_W-1:0] & ~reg_req_in.wdata))
    else $error("status write-one-clear wrong");

  a_status_set_wins: assert property (
    (clk_en_in && wr_sts_1x && pin_sync_q[0]) |=> status_q[0])
    else $error("status set lost to clear");

  a_request_held: assert property (
    (!wake_request_n_out && $stable(status_q) && $stable(enable_all)
     && wake_global_enable_q && clk_en_in && $past(clk_en_in))
    |=> !wake_request_n_out)
    else $error("wake request dropped while qualified");

  // Irq is built from the mask of the cycle before
  a_irq_level: assert property (
    clk_en_in |=> irq_out == |(int_sts_q & $past(int_mask_q)))
    else $error("irq does not follow unmasked status");

  a_read_idle_zero: assert property (
    (clk_en_in && !reg_req_in.rd) |=> rd_data_out == READ_ZERO)
    else $error("read data not zero outside answer cycle");

  c_wake_assert: cover property ($fell(wake_request_n_out));
  c_smi_only:    cover property (group_smi_out && wake_request_n_out);
  c_smi_assert:  cover property ($rose(group_smi_out));
  c_set_clear:   cover property (clk_en_in && wr_sts_1x && |pin_sync_q[DATA_W-1:0]);
  c_irq:         cover property ($rose(irq_out));

endmodule

// file: shared/wake_pkg.sv
package wake_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SRC_W  = 16;
  localparam int PIN_W  = 15;
  localparam int INT_W  = 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_EN_1X    = 8'h0b;
  localparam logic [ADDR_W-1:0] OFF_EN_2X    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STS_1X   = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STS_2X   = 8'h21;
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h22;
  localparam logic [ADDR_W-1:0] OFF_INT_STS  = 8'h23;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h24;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_BYTE     = 8'h00;
  localparam logic [SRC_W-1:0]  RST_SRC      = 16'h0000;
  localparam logic [INT_W-1:0]  RST_INT      = 2'h0;
  localparam logic [DATA_W-1:0] READ_ZERO    = 8'h00;
  localparam int                CTRL_GLOBAL  = 0;
  localparam int                SMI_EN_BIT   = 3;
  localparam int                NO_SRC_BIT   = 11;
  localparam logic [SRC_W-1:0]  SRC_PRESENT  = 16'hf7ff;
  localparam int                INT_STS_SET  = 0;
  localparam int                INT_REQ_RISE = 1;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_type;

endpackage

// file: verif/wake_sink.sv
module wake_sink
(
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic wake_request_n_in,
  output int        wake_count_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic req_n_q;

  // ----------------------------------------------------------------
  // Wake counting
  // ----------------------------------------------------------------
  // A held request is one wake, so only falling edges are counted
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      req_n_q        <= 1'b1;
      wake_count_out <= 0;
    end
    else
    begin
      req_n_q <= wake_request_n_in;
      if (req_n_q && !wake_request_n_in)
        wake_count_out <= wake_count_out + 1;
    end
  end
endmodule

// file: verif/tb.sv
module tb
  import wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys_in = 1'b0;
  logic              rst_n_in   = 1'b0;
  logic              clk_en_in  = 1'b1;
  reg_req_type       req        = '0;
  logic [PIN_W-1:0]  pins       = '0;
  logic [DATA_W-1:0] rd_data;
  logic              req_n;
  logic              smi;
  logic              irq;
  logic              rd_seen    = 1'b0;
  logic [DATA_W-1:0] exp_q[$];
  logic [SRC_W-1:0]  en_m;
  int                wakes_seen;
  int                bad_count  = 0;
  int                n_checks   = 0;
  int                seed       = 32'h2570_c3db;

  always #4 clk_sys_in = ~clk_sys_in;

  wake_source_enable_gating i_wake_source_enable_gating (
    .clk_sys_in         (clk_sys_in),
    .rst_n_in           (rst_n_in),
    .clk_en_in          (clk_en_in),
    .reg_req_in         (req),
    .wake_pin_in        (pins),
    .rd_data_out        (rd_data),
    .wake_request_n_out (req_n),
    .group_smi_out      (smi),
    .irq_out            (irq)
  );

  wake_sink i_wake_sink (
    .clk_sys_in        (clk_sys_in),
    .rst_n_in          (rst_n_in),
    .wake_request_n_in (req_n),
    .wake_count_out    (wakes_seen)
  );

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys_in)
  begin
    if (rd_seen)
      check(rd_data, exp_q.pop_front());
    rd_seen <= req.rd && clk_en_in && rst_n_in;
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys_in);
    bad_count++;
    results();
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // Leaves the strobe up so the next call runs back to back
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w)
      exp_q.push_back(d);
    @(posedge clk_sys_in);
  endtask

  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clk_sys_in);
  endtask

  // k: 0 on, 1 global off, 2 own bit off, 3 group SMI only with global off
  task automatic pulse(input int s, input int k);
    logic [SRC_W-1:0] sts;
    logic [SRC_W-1:0] en;
    sts = 16'h0001 << s;
    en  = (k == 2) ? ~sts : ((k == 3) ? (sts | 16'h0800) : sts);
    bus(1'b1, OFF_EN_1X, en[7:0]);
    bus(1'b1, OFF_EN_2X, en[15:8]);
    bus(1'b1, OFF_CTRL, {7'h00, k == 0 || k == 2});
    pins[(s < NO_SRC_BIT) ? s : s - 1] <= 1'b1;
    idle(6);
    check(req_n, k != 0);
    check(smi, k == 3);
    check(irq, 1'b0);
    bus(1'b0, OFF_STS_1X, sts[7:0]);
    bus(1'b0, OFF_STS_2X, sts[15:8]);
    pins <= '0;
    idle(3);
    bus(1'b1, OFF_STS_1X, 8'h00);
    bus(1'b1, OFF_STS_2X, 8'h00);
    bus(1'b0, OFF_STS_1X, sts[7:0]);
    bus(1'b0, OFF_STS_2X, sts[15:8]);
    bus(1'b1, OFF_STS_1X, sts[7:0]);
    bus(1'b1, OFF_STS_2X, sts[15:8]);
    bus(1'b1, OFF_INT_STS, 8'h03);
    bus(1'b0, OFF_STS_1X, 8'h00);
    bus(1'b0, OFF_STS_2X, 8'h00);
    idle(3);
    check(req_n, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] regs[8];
    regs = '{OFF_EN_1X, OFF_EN_2X, OFF_STS_1X, OFF_STS_2X,
             OFF_CTRL, OFF_INT_STS, OFF_INT_MASK, 8'h09};
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    foreach (regs[i])
      bus(1'b0, regs[i], 8'h00);
    repeat (4)
    begin
      en_m = 16'($random(seed));
      bus(1'b1, OFF_EN_1X, en_m[7:0]);
      bus(1'b1, OFF_EN_2X, en_m[15:8]);
      bus(1'b0, OFF_EN_1X, en_m[7:0]);
      bus(1'b0, OFF_EN_2X, en_m[15:8]);
    end
    // Strobe with the clock enable low must be dropped
    clk_en_in <= 1'b0;
    bus(1'b1, OFF_EN_1X, ~en_m[7:0]);
    clk_en_in <= 1'b1;
    bus(1'b0, OFF_EN_1X, en_m[7:0]);
    for (int s = 0; s < SRC_W; s++)
      if (s != NO_SRC_BIT)
        for (int k = 0; k < 4; k++)
          pulse(s, k);
    check(16'(wakes_seen), 16'd15);
    // Interrupt raised, cleared, then masked
    bus(1'b1, OFF_INT_MASK, 8'h01);
    pins[0] <= 1'b1;
    idle(6);
    check(irq, 1'b1);
    bus(1'b0, OFF_INT_STS, 8'h01);
    pins <= '0;
    idle(3);
    bus(1'b1, OFF_STS_1X, 8'h01);
    bus(1'b1, OFF_INT_STS, 8'h01);
    bus(1'b1, OFF_INT_MASK, 8'h02);
    idle(2);
    check(irq, 1'b0);
    pins[0] <= 1'b1;
    idle(6);
    check(irq, 1'b0);
    // Clear while the pin still stands must lose to the set
    bus(1'b1, OFF_STS_1X, 8'h01);
    bus(1'b0, OFF_STS_1X, 8'h01);
    bus(1'b0, OFF_INT_STS, 8'h01);
    pins <= '0;
    // Standby reset in mid-run clears the enables
    bus(1'b1, OFF_EN_1X, 8'ha5);
    bus(1'b1, OFF_EN_2X, 8'h5a);
    bus(1'b0, OFF_EN_2X, 8'h5a);
    idle(1);
    rst_n_in <= 1'b0;
    idle(2);
    rst_n_in <= 1'b1;
    idle(1);
    bus(1'b0, OFF_EN_1X, 8'h00);
    bus(1'b0, OFF_EN_2X, 8'h00);
    idle(3);
    results();
  end
endmodule
